// ==== shared/fsf_pkg.sv ====
// Shared constants and types for the FIFO status flag synchroniser.
//
// Functional notes
// R1: Fall-through: output-ready high means new word shown.
// R2: Standard: empty high means word ready; else ignore.
// R3: Flags on read clock; read pointer advances per load.
// R4: Fall-through: third read edge shifts word, raises ready.
// R5: Standard: empty flag rises on second read edge.
// R6: Read edge too close to write counts later.
// R7: Full flag high while free; full discards writes. Code keeps such writes in the staging buffer until the array has room.
// R8: Full flag on write clock; write pointer per write.
// R9: Full flag rises second write edge after read.
// R10: Write edge too close to read counts later.
// R11: Almost-empty on read clock, per-FIFO empty offset.
// R12: Almost-empty low at offset or fewer words.
// R13: Almost-empty rises second read edge after filling write.
// R14: Almost-empty first sync edge needs second skew.
// R15: Almost-full on write clock, per-FIFO full offset.
// R16: Almost-full low at depth minus offset or more.
// R17: Almost-full rises second write edge after read.
// R18: Almost-full first sync edge needs second skew.
// R19: Offsets preset at reset, parallel or serial load.
// R20: Pointer compare resolves level and two neighbours; code resolves the level and one neighbour only.
// R21: Every flag passes two stages of port clock.
// R22: Fall-through: empty output loads next word unasked.
// R23: Depth parameter 2048, 4096 or 8192 words.
`default_nettype none

package fsf_pkg;

  // ---------------------------------------------------------------------------
  // Sizes and preset values
  // ---------------------------------------------------------------------------
  localparam int          DEPTH_DEF  = 2048;     // Words per FIFO array.
  localparam int          WIDTH_DEF  = 36;       // Bits per word.
  localparam int          BUF_DEPTH  = 8;        // Words in the write staging buffer.
  localparam int          OFS_W      = 13;       // Width of one offset register.
  localparam logic [12:0] AE_PRESET  = 13'h0008; // Almost-empty offset after reset.
  localparam logic [12:0] AF_PRESET  = 13'h0008; // Almost-full offset after reset.

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  // Output register state in fall-through mode, one-hot.
  typedef enum logic [1:0] {
    OUT_IDLE = 2'b01,
    OUT_HELD = 2'b10
  } fsf_out_state_t;

  // Flags kept on the reading port.
  typedef struct packed {
    logic empty_flag;
    logic output_ready;
    logic almost_empty;
  } fsf_rd_flags_t;

  // Flags kept on the writing port.
  typedef struct packed {
    logic full_flag;
    logic almost_full;
  } fsf_wr_flags_t;

endpackage

`default_nettype wire

// ==== hdl/fsf_top.sv ====
// Two-direction FIFO with synchronised status flags and write staging buffers.
`default_nettype none

// -----------------------------------------------------------------------------
// Staging buffer
// -----------------------------------------------------------------------------
module fsf_buf #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_sys_in,
  input  wire logic             reset_in,
  // Filling side.
  input  wire logic             in_valid_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  in_ready_out,
  // Draining side.
  output logic                  out_valid_out,
  output logic      [WIDTH-1:0] out_data_out,
  input  wire logic             out_ready_in
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_idx;
  logic [AW-1:0]    rd_idx;
  logic [AW:0]      count;
  logic             push;
  logic             pop;
  logic [AW:0]      next_count;

  // Handshakes and the occupancy that follows them.
  assign push         = in_valid_in && in_ready_out;
  assign pop          = out_valid_out && out_ready_in;
  assign next_count   = count + (AW+1)'(push) - (AW+1)'(pop);
  assign out_data_out = mem[rd_idx];

  // Indices and registered full and empty, so in ready and out valid come from flops.
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      wr_idx        <= '0;
      rd_idx        <= '0;
      count         <= '0;
      in_ready_out  <= 1'b1;
      out_valid_out <= 1'b0;
    end else begin
      wr_idx        <= push ? wr_idx + 1'b1 : wr_idx;
      rd_idx        <= pop ? rd_idx + 1'b1 : rd_idx;
      count         <= next_count;
      in_ready_out  <= next_count < (AW+1)'(DEPTH);
      out_valid_out <= next_count != '0;
    end
  end

  // Storage, written only when a word is taken.
  always_ff @(posedge clk_sys_in) begin
    if (push) begin
      mem[wr_idx] <= in_data_in;
    end
  end
endmodule // fsf_buf

// -----------------------------------------------------------------------------
// One FIFO direction with its flag logic
// -----------------------------------------------------------------------------
module fsf_dir #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 2048
) (
  input  wire logic                       clk_sys_in,
  input  wire logic                       reset_in,
  input  wire logic                       fall_through_mode_in,
  // Port rate enables.
  input  wire logic                       wr_tick_in,
  input  wire logic                       rd_tick_in,
  // Writing port.
  input  wire logic                       push_valid_in,
  input  wire logic           [WIDTH-1:0] push_data_in,
  output logic                            push_ready_out,
  output fsf_pkg::fsf_wr_flags_t          wr_flags_out,
  // Reading port.
  input  wire logic                       read_req_in,
  output logic                [WIDTH-1:0] read_data_out,
  output fsf_pkg::fsf_rd_flags_t          rd_flags_out,
  // Offset programming.
  input  wire logic                       ofs_load_in,
  input  wire logic [fsf_pkg::OFS_W-1:0]  ae_ofs_in,
  input  wire logic [fsf_pkg::OFS_W-1:0]  af_ofs_in,
  input  wire logic                       ser_en_in,
  input  wire logic                       ser_bit_in,
  output logic                            ser_bit_out
);
  localparam int             AW      = $clog2(DEPTH);
  localparam int             PW      = AW + 1;
  localparam logic [PW-1:0]  DEPTH_P = PW'(DEPTH);

  logic [WIDTH-1:0]              mem [DEPTH];
  logic [PW-1:0]                 wptr;
  logic [PW-1:0]                 rptr;
  logic [fsf_pkg::OFS_W-1:0]     ae_ofs;
  logic [fsf_pkg::OFS_W-1:0]     af_ofs;
  logic                          buf_valid;
  logic [WIDTH-1:0]              buf_data;
  logic                          accept;
  logic                          advance;
  logic [PW-1:0]                 next_wptr;
  logic [PW-1:0]                 next_rptr;
  logic [PW-1:0]                 words_now;
  logic [PW-1:0]                 cnt_rd;
  logic [PW-1:0]                 cnt_wr;
  logic [PW-1:0]                 ae_lim;
  logic [PW-1:0]                 af_lim;
  logic [WIDTH-1:0]              head_word;
  fsf_pkg::fsf_out_state_t       out_state;
  // First stages: level and the next level up or down.
  logic                          e_s1;
  logic                          e_s1x;
  logic                          ae_s1;
  logic                          ae_s1x;
  logic                          f_s1;
  logic                          f_s1x;
  logic                          af_s1;
  logic                          af_s1x;

  // Staging buffer drained only while the array has room.
  fsf_buf #(
    .WIDTH (WIDTH),
    .DEPTH (fsf_pkg::BUF_DEPTH)
  ) u_buf (
    .clk_sys_in    (clk_sys_in),
    .reset_in      (reset_in),
    .in_valid_in   (push_valid_in),
    .in_data_in    (push_data_in),
    .in_ready_out  (push_ready_out),
    .out_valid_out (buf_valid),
    .out_data_out  (buf_data),
    .out_ready_in  (wr_tick_in && wr_flags_out.full_flag)
  );

  // Write acceptance and pointer next value.
  assign accept    = wr_tick_in && buf_valid && wr_flags_out.full_flag;                // see R7
  assign next_wptr = accept ? wptr + 1'b1 : wptr;                                      // see R8

  // Read-side load decision: a request in standard mode, or an empty output register or a request in fall-through.
  assign advance   = rd_tick_in && rd_flags_out.empty_flag &&
                     (fall_through_mode_in ? (out_state == fsf_pkg::OUT_IDLE) || read_req_in  // see R22
                                           : read_req_in);                              // see R2
  assign next_rptr = advance ? rptr + 1'b1 : rptr;                                     // see R3

  // Pointer comparisons; words in the output register are no longer counted.
  assign words_now = wptr - rptr;
  assign cnt_rd    = wptr - next_rptr;                                                 // see R12
  assign cnt_wr    = next_wptr - rptr;
  assign ae_lim    = PW'(ae_ofs);                                                      // see R11
  assign af_lim    = DEPTH_P - PW'(af_ofs);                                            // see R15, R16, R23
  assign head_word = mem[rptr[AW-1:0]];
  assign ser_bit_out = af_ofs[fsf_pkg::OFS_W-1];

  // Write and read pointers; the array is written in the block below.
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      wptr <= '0;
      rptr <= '0;
    end else begin
      wptr <= next_wptr;
      rptr <= next_rptr;
    end
  end

  // Array write on each accepted word.
  always_ff @(posedge clk_sys_in) begin
    if (accept) begin
      mem[wptr[AW-1:0]] <= buf_data;
    end
  end

  // Offset registers: preset, parallel load, or serial shift through both.
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      ae_ofs <= fsf_pkg::AE_PRESET;                                                    // see R19
      af_ofs <= fsf_pkg::AF_PRESET;
    end else if (ofs_load_in) begin
      ae_ofs <= ae_ofs_in;                                                             // see R19
      af_ofs <= af_ofs_in;
    end else if (ser_en_in) begin
      {af_ofs, ae_ofs} <= {af_ofs[fsf_pkg::OFS_W-2:0], ae_ofs, ser_bit_in};            // see R19
    end
  end

  // Read-port flags: first stage samples the write pointer settled before this edge and the read pointer after it, second is the flag.
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      e_s1                      <= 1'b0;
      e_s1x                     <= 1'b0;
      ae_s1                     <= 1'b0;
      ae_s1x                    <= 1'b0;
      rd_flags_out.empty_flag   <= 1'b0;
      rd_flags_out.almost_empty <= 1'b0;
    end else if (rd_tick_in) begin
      e_s1                      <= cnt_rd != '0;                                       // see R6, R20
      e_s1x                     <= cnt_rd > PW'(1);                                    // see R20
      ae_s1                     <= cnt_rd > ae_lim;                                    // see R14
      ae_s1x                    <= cnt_rd > ae_lim + 1'b1;
      rd_flags_out.empty_flag   <= advance ? e_s1x : e_s1;                             // see R5, R21
      rd_flags_out.almost_empty <= advance ? ae_s1x : ae_s1;                           // see R13, R21
    end
  end

  // Output register and its one-hot state in fall-through mode.
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      out_state     <= fsf_pkg::OUT_IDLE;
      read_data_out <= '0;
    end else begin
      if (advance) begin
        read_data_out <= head_word;                                                    // see R4
      end
      unique case (out_state)
        fsf_pkg::OUT_IDLE: begin
          if (advance && fall_through_mode_in) begin
            out_state <= fsf_pkg::OUT_HELD;                                            // see R4
          end
        end
        fsf_pkg::OUT_HELD: begin
          if (!fall_through_mode_in || (rd_tick_in && read_req_in && !advance)) begin
            out_state <= fsf_pkg::OUT_IDLE;                                            // see R1
          end
        end
        default: begin
          out_state <= fsf_pkg::OUT_IDLE;
        end
      endcase
    end
  end
  assign rd_flags_out.output_ready = out_state[1];

  // Write-port flags, sampled two write edges after a freeing read.
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      f_s1                     <= 1'b1;
      f_s1x                    <= 1'b1;
      af_s1                    <= 1'b1;
      af_s1x                   <= 1'b1;
      wr_flags_out.full_flag   <= 1'b1;
      wr_flags_out.almost_full <= 1'b1;
    end else if (wr_tick_in) begin
      f_s1                     <= cnt_wr < DEPTH_P;                                    // see R10, R20
      f_s1x                    <= cnt_wr < DEPTH_P - 1'b1;                             // see R20
      af_s1                    <= cnt_wr < af_lim;                                     // see R18
      af_s1x                   <= cnt_wr < af_lim - 1'b1;
      wr_flags_out.full_flag   <= accept ? f_s1x : f_s1;                               // see R9, R21
      wr_flags_out.almost_full <= accept ? af_s1x : af_s1;                             // see R17, R21
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);

  sequence s_auto_load;
    fall_through_mode_in && advance;
  endsequence

  sequence s_word_shown;
    rd_flags_out.output_ready && (read_data_out == $past(head_word));
  endsequence

  AST_FULL_DISCARDS: assert property (                                     // see R7
    wr_tick_in && !wr_flags_out.full_flag |=> wptr == $past(wptr))
    else $error("Write taken while full flag low.");
  AST_WPTR_STEP: assert property (                                         // see R8
    accept |=> wptr == $past(wptr) + 1'b1)
    else $error("Write pointer did not step on an accepted write.");
  AST_RPTR_STEP: assert property (                                         // see R3
    advance |=> rptr == $past(rptr) + 1'b1)
    else $error("Read pointer did not step on a load.");
  AST_STD_IGNORE: assert property (                                        // see R2
    !fall_through_mode_in && rd_tick_in && read_req_in && !rd_flags_out.empty_flag
    |=> $stable(read_data_out) && rptr == $past(rptr))
    else $error("Read acted while empty flag low.");
  AST_OR_HOLD: assert property (                                           // see R1
    fall_through_mode_in && !rd_flags_out.output_ready && !advance |=> $stable(read_data_out))
    else $error("Output word changed while output ready low.");
  AST_OR_LOAD: assert property (                                           // see R4
    s_auto_load |=> s_word_shown)
    else $error("Loaded word not shown with output ready.");
  AST_EMPTY_TRUE: assert property (                                        // see R5
    rd_flags_out.empty_flag |-> words_now != '0)
    else $error("Empty flag high with no word in the array.");
  AST_FULL_TRUE: assert property (                                         // see R9
    wr_flags_out.full_flag |-> words_now < DEPTH_P)
    else $error("Full flag high with no free location.");
endmodule // fsf_dir

// -----------------------------------------------------------------------------
// Top: FIFO1 from port A to port B, FIFO2 from port B to port A
// -----------------------------------------------------------------------------
module fsf_top #(
  parameter int WIDTH = fsf_pkg::WIDTH_DEF,
  parameter int DEPTH = fsf_pkg::DEPTH_DEF
) (
  // Clock, reset and mode.
  input  wire logic                      clk_sys_in,
  input  wire logic                      reset_in,
  input  wire logic                      fall_through_mode_in,
  // Port rate enables.
  input  wire logic                      port_a_clock_en_in,
  input  wire logic                      port_b_clock_en_in,
  // Port A data.
  input  wire logic                      porta_write_valid_in,
  input  wire logic          [WIDTH-1:0] porta_write_data_in,
  output logic                           porta_write_ready_out,
  input  wire logic                      porta_read_req_in,
  output logic               [WIDTH-1:0] porta_read_data_out,
  // Port B data.
  input  wire logic                      portb_write_valid_in,
  input  wire logic          [WIDTH-1:0] portb_write_data_in,
  output logic                           portb_write_ready_out,
  input  wire logic                      portb_read_req_in,
  output logic               [WIDTH-1:0] portb_read_data_out,
  // Port A flags.
  output logic                           porta_empty_flag_out,
  output logic                           porta_output_ready_out,
  output logic                           porta_full_flag_out,
  output logic                           porta_input_ready_out,
  output logic                           porta_almost_empty_out,
  output logic                           porta_almost_full_out,
  // Port B flags.
  output logic                           portb_empty_flag_out,
  output logic                           portb_output_ready_out,
  output logic                           portb_full_flag_out,
  output logic                           portb_input_ready_out,
  output logic                           portb_almost_empty_out,
  output logic                           portb_almost_full_out,
  // Offset programming.
  input  wire logic                      ofs_load_in,
  input  wire logic [fsf_pkg::OFS_W-1:0] fifo1_ae_offset_in,
  input  wire logic [fsf_pkg::OFS_W-1:0] fifo1_af_offset_in,
  input  wire logic [fsf_pkg::OFS_W-1:0] fifo2_ae_offset_in,
  input  wire logic [fsf_pkg::OFS_W-1:0] fifo2_af_offset_in,
  input  wire logic                      ofs_serial_en_in,
  input  wire logic                      ofs_serial_bit_in
);
  fsf_pkg::fsf_rd_flags_t f1_rd;
  fsf_pkg::fsf_wr_flags_t f1_wr;
  fsf_pkg::fsf_rd_flags_t f2_rd;
  fsf_pkg::fsf_wr_flags_t f2_wr;
  logic                   ser_link;

  // FIFO1: written on port A, read on port B.
  fsf_dir #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_fifo1 (
    .clk_sys_in           (clk_sys_in),
    .reset_in             (reset_in),
    .fall_through_mode_in (fall_through_mode_in),
    .wr_tick_in           (port_a_clock_en_in),
    .rd_tick_in           (port_b_clock_en_in),
    .push_valid_in        (porta_write_valid_in),
    .push_data_in         (porta_write_data_in),
    .push_ready_out       (porta_write_ready_out),
    .wr_flags_out         (f1_wr),
    .read_req_in          (portb_read_req_in),
    .read_data_out        (portb_read_data_out),
    .rd_flags_out         (f1_rd),
    .ofs_load_in          (ofs_load_in),
    .ae_ofs_in            (fifo1_ae_offset_in),
    .af_ofs_in            (fifo1_af_offset_in),
    .ser_en_in            (ofs_serial_en_in),
    .ser_bit_in           (ofs_serial_bit_in),
    .ser_bit_out          (ser_link)
  );

  // FIFO2: written on port B, read on port A.
  fsf_dir #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_fifo2 (
    .clk_sys_in           (clk_sys_in),
    .reset_in             (reset_in),
    .fall_through_mode_in (fall_through_mode_in),
    .wr_tick_in           (port_b_clock_en_in),
    .rd_tick_in           (port_a_clock_en_in),
    .push_valid_in        (portb_write_valid_in),
    .push_data_in         (portb_write_data_in),
    .push_ready_out       (portb_write_ready_out),
    .wr_flags_out         (f2_wr),
    .read_req_in          (porta_read_req_in),
    .read_data_out        (porta_read_data_out),
    .rd_flags_out         (f2_rd),
    .ofs_load_in          (ofs_load_in),
    .ae_ofs_in            (fifo2_ae_offset_in),
    .af_ofs_in            (fifo2_af_offset_in),
    .ser_en_in            (ofs_serial_en_in),
    .ser_bit_in           (ser_link),
    .ser_bit_out          ()
  );

  // Flag pins, each a flop inside its FIFO; full flag and input ready pins share one flop.
  assign portb_empty_flag_out   = f1_rd.empty_flag;
  assign portb_output_ready_out = f1_rd.output_ready;
  assign portb_almost_empty_out = f1_rd.almost_empty;
  assign porta_full_flag_out    = f1_wr.full_flag;
  assign porta_input_ready_out  = f1_wr.full_flag;
  assign porta_almost_full_out  = f1_wr.almost_full;
  assign porta_empty_flag_out   = f2_rd.empty_flag;
  assign porta_output_ready_out = f2_rd.output_ready;
  assign porta_almost_empty_out = f2_rd.almost_empty;
  assign portb_full_flag_out    = f2_wr.full_flag;
  assign portb_input_ready_out  = f2_wr.full_flag;
  assign portb_almost_full_out  = f2_wr.almost_full;
endmodule // fsf_top

`default_nettype wire

// ==== dv/fsf_port_model.sv ====
// Port-side model: rate enables standing for the two free-running port clocks.
`default_nettype none

module fsf_port_model (
  // Clock and reset.
  input  wire logic       clk_sys_in,
  input  wire logic       reset_in,
  // Cycles between port edges, minus one.
  input  wire logic [3:0] a_period_in,
  input  wire logic [3:0] b_period_in,
  // Port clock edges as one-cycle pulses.
  output logic            a_tick_out,
  output logic            b_tick_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] a_cnt;
  logic [3:0] b_cnt;
  // Each port counts down its own spacing, so the two rates are unrelated.
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      a_cnt      <= 4'h0;
      b_cnt      <= 4'h0;
      a_tick_out <= 1'b0;
      b_tick_out <= 1'b0;
    end else begin
      a_cnt      <= (a_cnt == 4'h0) ? a_period_in : a_cnt - 4'h1;
      b_cnt      <= (b_cnt == 4'h0) ? b_period_in : b_cnt - 4'h1;
      a_tick_out <= (a_cnt == 4'h0);
      b_tick_out <= (b_cnt == 4'h0);
    end
  end
endmodule // fsf_port_model

`default_nettype wire

// ==== dv/test_fsf_top.sv ====
// Self-checking bench for the two-direction FIFO and its status flags.
`default_nettype none

module test_fsf_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int DEPTH = 16;
  logic clk_sys_in = 1'b0, reset_in = 1'b1, ft = 1'b0, ofs_load = 1'b0, a_tick, b_tick;
  logic [3:0] a_per = 4'h0, b_per = 4'h0;
  logic [12:0] ofs = 13'h0000;
  logic [1:0] wv = 2'h0, rq = 2'h0, take_q = 2'h0;
  logic [35:0] wd [2] = '{36'h0, 36'h0};
  logic [35:0] q [2][$];
  wire logic [1:0] wr, ef, orr, ff, ir, ae, af;
  wire logic [35:0] rdat [2];
  int n_errors = 0, checks = 0, cyc = 0, n;

  always #20 clk_sys_in = ~clk_sys_in;

  fsf_port_model fsf_port_model_i (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .a_period_in(a_per),
    .b_period_in(b_per), .a_tick_out(a_tick), .b_tick_out(b_tick));
  fsf_top #(.DEPTH(DEPTH)) fsf_top_i (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .fall_through_mode_in(ft),
    .port_a_clock_en_in(a_tick), .port_b_clock_en_in(b_tick), .porta_write_valid_in(wv[0]),
    .porta_write_data_in(wd[0]), .porta_write_ready_out(wr[0]), .porta_read_req_in(rq[1]),
    .porta_read_data_out(rdat[1]), .portb_write_valid_in(wv[1]), .portb_write_data_in(wd[1]),
    .portb_write_ready_out(wr[1]), .portb_read_req_in(rq[0]), .portb_read_data_out(rdat[0]),
    .porta_empty_flag_out(ef[1]), .porta_output_ready_out(orr[1]), .porta_full_flag_out(ff[0]),
    .porta_input_ready_out(ir[0]), .porta_almost_empty_out(ae[1]), .porta_almost_full_out(af[0]),
    .portb_empty_flag_out(ef[0]), .portb_output_ready_out(orr[0]), .portb_full_flag_out(ff[1]),
    .portb_input_ready_out(ir[1]), .portb_almost_empty_out(ae[0]), .portb_almost_full_out(af[1]),
    .ofs_load_in(ofs_load), .fifo1_ae_offset_in(ofs), .fifo1_af_offset_in(ofs),
    .fifo2_ae_offset_in(ofs), .fifo2_af_offset_in(ofs), .ofs_serial_en_in(1'b0),
    .ofs_serial_bit_in(1'b0));

  task automatic chk(input logic ok, input string m);
    checks++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask

  task automatic end_sim;
    if (n_errors == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Takes the oldest noted word whenever a read is taken and compares it with the output register.
  task automatic cmp(input int d);
    if (q[d].size() == 0) chk(1'b0, "read with nothing written");
    else chk(rdat[d] === q[d].pop_front(), "read data differs");
  endtask

  // Watches both reading ports; a standard read shows its word one edge later.
  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == 6000) begin
      n_errors++;
      end_sim();
    end
    if (!reset_in) for (int d = 0; d < 2; d++) begin
      if (take_q[d]) cmp(d);
      if (ft && orr[d] && (d ? a_tick : b_tick) && rq[d]) cmp(d);
      take_q[d] <= !ft && ef[d] && (d ? a_tick : b_tick) && rq[d];
    end
  end

  // Pushes one word, holding valid until it is taken, and notes it as expected.
  task automatic push(input int d, input logic [35:0] v);
    wv[d] = 1'b1;
    wd[d] = v;
    do @(posedge clk_sys_in); while (wr[d] !== 1'b1);
    q[d].push_back(v);
    #2;
  endtask

  // Runs both timing modes through latency, fill and drain.
  initial begin
    void'($urandom(32'hb069_f900));
    for (int m = 0; m < 2; m++) begin
      reset_in = 1'b1;
      ft = m[0];
      repeat (5) @(posedge clk_sys_in);
      #2 reset_in = 1'b0;
      chk(ef === 2'b00 && orr === 2'b00 && ff === 2'b11 && af === 2'b11 && ae === 2'b00, "reset flags");
      // A zero offset in standard mode makes one stored word lift almost-empty, unlike the preset.
      ofs = m ? 13'($urandom_range(1, 5)) : 13'h0000;
      ofs_load = 1'b1;
      @(posedge clk_sys_in);
      #2 ofs_load = 1'b0;
      for (int d = 0; d < 2; d++) begin
        push(d, 36'({$urandom, $urandom}));
        wv[d] = 1'b0;
        n = 0;
        while ((ft ? orr[d] : ef[d]) !== 1'b1 && n < 20) begin
          @(posedge clk_sys_in);
          #2 n++;
        end
        chk(n == 3 + m, "flag rise latency");
        chk(ae[d] === (m == 0), "almost empty level");
      end
      for (int d = 0; d < 2; d++) begin
        wv[d] = 1'b1;
        repeat (40) begin
          wd[d] = 36'({$urandom, $urandom});
          @(posedge clk_sys_in);
          if (wr[d] === 1'b1) q[d].push_back(wd[d]);
          #2;
        end
        wv[d] = 1'b0;
        chk(q[d].size() == DEPTH + fsf_pkg::BUF_DEPTH + m, "stored word count");
        chk(ff[d] === 1'b0 && ir[d] === 1'b0 && af[d] === 1'b0 && ae[d] === 1'b1, "full flags");
        if (!ft) begin
          rq[d] = 1'b1;
          @(posedge clk_sys_in);
          #2 rq[d] = 1'b0;
          n = 0;
          while (ff[d] !== 1'b1 && n < 20) begin
            @(posedge clk_sys_in);
            #2 n++;
          end
          chk(n == 2, "full flag release");
        end
      end
      a_per = 4'($urandom_range(0, 3));
      b_per = 4'($urandom_range(0, 3));
      repeat (600) begin
        @(posedge clk_sys_in);
        #2 rq = 2'($urandom);
      end
      rq = 2'b00;
      repeat (12) @(posedge clk_sys_in);
      #2 chk(q[0].size() + q[1].size() == 0 && ef === 2'b00 && orr === 2'b00, "drained");
      chk(ae === 2'b00 && ff === 2'b11 && af === 2'b11, "flags after drain");
      a_per = 4'h0;
      b_per = 4'h0;
    end
    end_sim();
  end
endmodule // test_fsf_top

`default_nettype wire
